// *** core/config_word_pkg.sv ***
// Package with configuration word layout, decode types and timing constants.
package config_word_pkg;

  localparam int unsigned CFG_W            = 14;
  localparam logic [13:0] CFG_WORD_ADDR    = 14'h2007;
  localparam logic [13:0] CAL_WORD_ADDR    = 14'h2008;
  localparam logic [13:0] CFG_SPACE_LO     = 14'h2000;
  localparam logic [13:0] CFG_ERASED       = 14'h3FFF;

  localparam int unsigned FOSC_LSB         = 0;
  localparam int unsigned WATCHDOG_ENABLE_BIT         = 3;
  localparam int unsigned POWER_UP_DELAY_ENABLE_BIT        = 4;
  localparam int unsigned EXT_RESET_PIN_SELECT_BIT        = 5;
  localparam int unsigned CP_BIT           = 6;
  localparam int unsigned INT_OSC_FREQ_SELECT_BIT       = 7;
  localparam int unsigned BORSEL_LSB       = 8;
  localparam int unsigned WRT_LSB          = 10;
  localparam logic [3:0]  UNUSED_HI_STD    = 4'hF;
  localparam logic [1:0]  UNUSED_HI_SW     = 2'h3;

  localparam logic [1:0]  BOR_ALWAYS       = 2'h3;
  localparam logic [1:0]  BOR_RUN_ONLY     = 2'h2;

  localparam logic [1:0]  WRT_NONE         = 2'h3;
  localparam logic [1:0]  WRT_TO_1FF       = 2'h2;
  localparam logic [1:0]  WRT_TO_3FF       = 2'h1;
  localparam logic [10:0] WRT_LIM_1FF      = 11'h1FF;
  localparam logic [10:0] WRT_LIM_3FF      = 11'h3FF;
  localparam logic [10:0] WRT_LIM_7FF      = 11'h7FF;

  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned POWER_UP_DELAY_TIMER_MS          = 64;
  localparam int unsigned POWER_UP_DELAY_TIMER_CYCLES      = POWER_UP_DELAY_TIMER_MS * 1000 * CLK_MHZ;
  localparam int unsigned OST_PERIODS      = 1024;

  typedef enum logic [2:0] {
    OSC_LP_XTAL   = 3'h0,
    OSC_STD_XTAL  = 3'h1,
    OSC_HS_XTAL   = 3'h2,
    OSC_EXT_CLK   = 3'h3,
    OSC_INT_IO    = 3'h4,
    OSC_INT_CLKO  = 3'h5,
    OSC_RC_IO     = 3'h6,
    OSC_RC_CLKO   = 3'h7
  } osc_mode_t;

  typedef struct packed {
    osc_mode_t   osc_mode;
    logic        crystal_mode;
    logic        clock_output_pin_en;
    logic        int_osc_8mhz;
    logic        watchdog_enable;
    logic        power_up_delay_en;
    logic        ext_reset_pin_en;
    logic        weak_pullup_en;
    logic        code_protect_en;
    logic        brownout_run_en;
    logic        brownout_sleep_en;
    logic [10:0] write_protect_limit;
    logic        write_protect_any;
  } cfg_decoded_t;

  typedef enum logic [2:0] {
    ST_POR   = 3'b000,
    ST_POWER_UP_DELAY_TIMER  = 3'b001,
    ST_OST   = 3'b011,
    ST_RUN   = 3'b010,
    ST_BOR   = 3'b110
  } rst_state_t;

endpackage : config_word_pkg

// *** core/config_word_decode.sv ***
// Configuration word decoder with power-up and start-up reset sequencing.
// Functional notes
// - Power-up delay holds reset 64 ms after power-up.
// - Start-up timer holds reset until crystal stable.
// - Brown-out resets; may stretch with power-up delay.
// - Sleep exits on external reset, watchdog, interrupt.
// - Programmed bit reads zero, unprogrammed reads one.
// - Configuration word at 2007h, programmer-only access.
// - Unused upper configuration bits always read one.
// - Brown-out select: 11 always, 10 run, 0x off.
// - Frequency select bit: set 8 MHz, clear 4 MHz.
// - Bit 6 cleared enables code protection.
// - Protection turned off erases whole program memory.
// - Reset-pin bit set makes pin active-low reset.
// - Self-write variant: reset pin gets weak pull-up.
// - Bit 4 cleared enables power-up delay timer.
// - Watchdog enable bit set turns watchdog on.
// - Three-bit oscillator field selects eight clock modes.
// - Brown-out enable never enables power-up delay.
// - Reset pin asserted stops internal or RC oscillator.
// - Write-protect field limits self-write ranges.
// - Calibration word at 2008h survives bulk erase.
// - Power-up delay runs first, then start-up timer.
// - Brown-out during delay restarts full 64 ms delay.
`timescale 1ns/100ps
`default_nettype none

module config_word_decode #(
  parameter bit          SELF_WRITE  = 1'b0,
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = config_word_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  // Programmer port into configuration space.
  input  wire logic                          i_prog_mode,
  input  wire logic                          i_prog_wr,
  input  wire logic                          i_prog_bulk_erase,
  input  wire logic [13:0]                   i_prog_addr,
  input  wire logic [13:0]                   i_prog_wdata,
  output logic      [13:0]                   o_prog_rdata,
  // Analog and pin events, asynchronous to i_clock.
  input  wire logic                          i_brownout_n,
  input  wire logic                          i_master_clear_pin,
  input  wire logic                          i_osc_tick,
  input  wire logic                          i_sleeping,
  input  wire logic                          i_wdt_wake,
  input  wire logic                          i_irq_wake,
  output config_word_pkg::cfg_decoded_t      o_cfg,
  output logic                               o_core_reset,
  output logic                               o_sleep_exit,
  output logic                               o_osc_stop,
  output logic                               o_prog_mem_erase,
  output logic                               o_prog_mem_read_block
);

  localparam int unsigned CNT_W = 32;

  // Nonvolatile words; i_rst_n, which only models power-on, loads them with the erased value.
  logic [13:0] config_word_q;
  logic [13:0] cal_word_q;
  logic        in_cfg_space;

  // Two-flop synchronisers for every asynchronous input except i_sleeping.
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic       bor_n_s;
  logic       master_clear_pin_s;
  logic       tick_s;
  logic       wdt_s;
  logic       irq_s;
  logic       tick_prev_q;
  logic       tick_rise;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      // Brown-out and pin inputs start at their idle high level, so the
      // release of reset is not mistaken for a brown-out or pin reset.
      meta_q <= 5'h03;
      sync_q <= 5'h03;
    end
    else
    begin
      meta_q <= {i_irq_wake, i_wdt_wake, i_osc_tick,
                 i_master_clear_pin, i_brownout_n};
      sync_q <= meta_q;
    end
  end

  assign bor_n_s   = sync_q[0];
  assign master_clear_pin_s    = sync_q[1];
  assign tick_s    = sync_q[2];
  assign wdt_s     = sync_q[3];
  assign irq_s     = sync_q[4];
  assign tick_rise = tick_s & ~tick_prev_q;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tick_prev_q <= 1'b0;
    else
      tick_prev_q <= tick_s;
  end

  // Only the programmer reaches 2000h and up; running code has no path.
  assign in_cfg_space = i_prog_mode &&
                        (i_prog_addr >= config_word_pkg::CFG_SPACE_LO);

  // Unused bits are forced high whatever the programmer writes.
  function automatic logic [13:0] pad_unused(input logic [13:0] w);
    logic [13:0] r;
    r = w;
    if (SELF_WRITE)
      r[13:12] = config_word_pkg::UNUSED_HI_SW;
    else
      r[13:10] = config_word_pkg::UNUSED_HI_STD;
    return r;
  endfunction : pad_unused

  logic cp_release;
  // Outside bulk erase, protection turns off only when an enabled CP bit is written high.
  assign cp_release = in_cfg_space && i_prog_wr &&
                      (i_prog_addr == config_word_pkg::CFG_WORD_ADDR) &&
                      !config_word_q[config_word_pkg::CP_BIT] &&
                      i_prog_wdata[config_word_pkg::CP_BIT];

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      config_word_q    <= config_word_pkg::CFG_ERASED;
      o_prog_mem_erase <= 1'b0;
    end
    else
    begin
      o_prog_mem_erase <= cp_release || (in_cfg_space && i_prog_bulk_erase);
      if (in_cfg_space && i_prog_bulk_erase)
        config_word_q <= config_word_pkg::CFG_ERASED;
      else if (in_cfg_space && i_prog_wr &&
               i_prog_addr == config_word_pkg::CFG_WORD_ADDR)
        config_word_q <= pad_unused(i_prog_wdata);
    end
  end

  // Calibration fuses ignore bulk erase; only a direct write changes them.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cal_word_q <= config_word_pkg::CFG_ERASED;
    else if (in_cfg_space && i_prog_wr && !i_prog_bulk_erase &&
             i_prog_addr == config_word_pkg::CAL_WORD_ADDR)
      cal_word_q <= i_prog_wdata;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_prog_rdata <= 14'h0000;
    else if (!in_cfg_space)
      o_prog_rdata <= 14'h0000;
    else if (i_prog_addr == config_word_pkg::CFG_WORD_ADDR)
      o_prog_rdata <= pad_unused(config_word_q);
    else if (i_prog_addr == config_word_pkg::CAL_WORD_ADDR)
      o_prog_rdata <= cal_word_q;
    else
      o_prog_rdata <= 14'h0000;
  end

  // Decode of the stored word, captured only while the core is in reset.
  function automatic config_word_pkg::cfg_decoded_t decode(
    input logic [13:0] w);
    config_word_pkg::cfg_decoded_t d;
    logic [1:0] bsel;
    logic [1:0] wrt;
    d = '0;
    bsel = w[config_word_pkg::BORSEL_LSB +: 2];
    wrt  = w[config_word_pkg::WRT_LSB +: 2];
    d.osc_mode = config_word_pkg::osc_mode_t'(
      w[config_word_pkg::FOSC_LSB +: 3]);
    d.crystal_mode = (d.osc_mode == config_word_pkg::OSC_LP_XTAL) ||
                     (d.osc_mode == config_word_pkg::OSC_STD_XTAL) ||
                     (d.osc_mode == config_word_pkg::OSC_HS_XTAL);
    d.clock_output_pin_en = (d.osc_mode == config_word_pkg::OSC_INT_CLKO) ||
                  (d.osc_mode == config_word_pkg::OSC_RC_CLKO);
    d.int_osc_8mhz = w[config_word_pkg::INT_OSC_FREQ_SELECT_BIT];
    d.watchdog_enable = w[config_word_pkg::WATCHDOG_ENABLE_BIT];
    d.power_up_delay_en = !w[config_word_pkg::POWER_UP_DELAY_ENABLE_BIT];
    d.ext_reset_pin_en = w[config_word_pkg::EXT_RESET_PIN_SELECT_BIT];
    d.weak_pullup_en = SELF_WRITE && w[config_word_pkg::EXT_RESET_PIN_SELECT_BIT];
    d.code_protect_en = !w[config_word_pkg::CP_BIT];
    d.brownout_run_en = bsel[1];
    d.brownout_sleep_en = (bsel == config_word_pkg::BOR_ALWAYS);
    if (!SELF_WRITE || wrt == config_word_pkg::WRT_NONE)
    begin
      d.write_protect_any   = 1'b0;
      d.write_protect_limit = 11'h000;
    end
    else
    begin
      d.write_protect_any = 1'b1;
      case (wrt)
        config_word_pkg::WRT_TO_1FF:
          d.write_protect_limit = config_word_pkg::WRT_LIM_1FF;
        config_word_pkg::WRT_TO_3FF:
          d.write_protect_limit = config_word_pkg::WRT_LIM_3FF;
        default:
          d.write_protect_limit = config_word_pkg::WRT_LIM_7FF;
      endcase
    end
    return d;
  endfunction : decode

  // Reset sequencer.
  config_word_pkg::rst_state_t state_q;
  config_word_pkg::rst_state_t state_d;
  logic [CNT_W-1:0]            power_up_delay_timer_cnt_q;
  logic [10:0]                 ost_cnt_q;
  logic                        bor_active;
  logic                        ext_reset;
  logic                        power_up_delay_timer_done;
  logic                        ost_done;

  assign bor_active = !bor_n_s &&
    (i_sleeping ? o_cfg.brownout_sleep_en : o_cfg.brownout_run_en);
  // With the pin function off the internal reset stays inactive.
  assign ext_reset = o_cfg.ext_reset_pin_en && !master_clear_pin_s;
  assign power_up_delay_timer_done = !o_cfg.power_up_delay_en ||
                     (power_up_delay_timer_cnt_q == CNT_W'(POWER_UP_DELAY_TIMER_CYCLES - 1));
  assign ost_done  = !o_cfg.crystal_mode ||
                     (ost_cnt_q == 11'(config_word_pkg::OST_PERIODS));

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      config_word_pkg::ST_POR:
        state_d = config_word_pkg::ST_POWER_UP_DELAY_TIMER;
      config_word_pkg::ST_POWER_UP_DELAY_TIMER:
        if (bor_active)
          state_d = config_word_pkg::ST_BOR;
        else if (power_up_delay_timer_done)
          state_d = config_word_pkg::ST_OST;
      config_word_pkg::ST_OST:
        if (bor_active)
          state_d = config_word_pkg::ST_BOR;
        else if (ost_done)
          state_d = config_word_pkg::ST_RUN;
      config_word_pkg::ST_RUN:
        if (bor_active)
          state_d = config_word_pkg::ST_BOR;
      config_word_pkg::ST_BOR:
        if (!bor_active)
          state_d = config_word_pkg::ST_POWER_UP_DELAY_TIMER;
      default:
        state_d = config_word_pkg::ST_POR;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_q <= config_word_pkg::ST_POR;
    else
      state_q <= state_d;
  end

  // The delay counter restarts from zero on every entry to the delay.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      power_up_delay_timer_cnt_q <= '0;
    else if (state_q != config_word_pkg::ST_POWER_UP_DELAY_TIMER)
      power_up_delay_timer_cnt_q <= '0;
    else if (!power_up_delay_timer_done)
      power_up_delay_timer_cnt_q <= power_up_delay_timer_cnt_q + CNT_W'(1);
  end

  // Start-up timer counts oscillator edges, not system clocks.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ost_cnt_q <= 11'h000;
    else if (state_q != config_word_pkg::ST_OST)
      ost_cnt_q <= 11'h000;
    else if (tick_rise && !ost_done)
      ost_cnt_q <= ost_cnt_q + 11'h001;
  end

  // Options latch only in the power-on and brown-out states so a programmer write mid-run
  // cannot change the running configuration.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_cfg <= decode(config_word_pkg::CFG_ERASED);
    else if (state_q == config_word_pkg::ST_POR ||
             state_q == config_word_pkg::ST_BOR)
      o_cfg <= decode(config_word_q);
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_core_reset          <= 1'b1;
      o_sleep_exit          <= 1'b0;
      o_osc_stop            <= 1'b0;
      o_prog_mem_read_block <= 1'b0;
    end
    else
    begin
      o_core_reset <= (state_q != config_word_pkg::ST_RUN) || ext_reset;
      o_sleep_exit <= i_sleeping && (ext_reset || wdt_s || irq_s);
      o_osc_stop <= ext_reset && !o_cfg.crystal_mode &&
                    o_cfg.osc_mode != config_word_pkg::OSC_EXT_CLK;
      o_prog_mem_read_block <= o_cfg.code_protect_en;
    end
  end

endmodule : config_word_decode

`default_nettype wire

// *** dv/config_word_decode_sva.sv ***
// Port-level checker for the configuration word decoder.
`timescale 1ns/100ps
`default_nettype none
module config_word_decode_sva #(
  parameter bit          SELF_WRITE  = 1'b0,
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = config_word_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
  input wire logic                          i_clock,
  input wire logic                          i_rst_n,
  input wire logic                          i_prog_mode,
  input wire logic                          i_prog_wr,
  input wire logic                          i_prog_bulk_erase,
  input wire logic [13:0]                   i_prog_addr,
  input wire logic [13:0]                   i_prog_wdata,
  input wire logic [13:0]                   o_prog_rdata,
  input wire logic                          i_sleeping,
  input wire config_word_pkg::cfg_decoded_t o_cfg,
  input wire logic                          o_core_reset,
  input wire logic                          o_sleep_exit,
  input wire logic                          o_osc_stop,
  input wire logic                          o_prog_mem_erase,
  input wire logic                          o_prog_mem_read_block
);
  localparam logic [13:0] PAD = SELF_WRITE ? 14'h3000 : 14'h3C00;
  int unsigned hi_q;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Saturating, so the default delay length never overflows the counter.
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      hi_q <= 0;
    else if (!o_core_reset)
      hi_q <= 0;
    else if (hi_q < POWER_UP_DELAY_TIMER_CYCLES)
      hi_q <= hi_q + 1;
  end
  sequence s_cfg_wr;
    i_prog_mode && i_prog_wr && !i_prog_bulk_erase &&
      i_prog_addr == config_word_pkg::CFG_WORD_ADDR;
  endsequence
  sequence s_cfg_rd;
    i_prog_mode && !i_prog_wr && !i_prog_bulk_erase &&
      i_prog_addr == config_word_pkg::CFG_WORD_ADDR;
  endsequence
  a_cfg_write_read: assert property (
    s_cfg_wr ##1 s_cfg_rd |=> o_prog_rdata == ($past(i_prog_wdata, 2) | PAD))
    else $error("config word read back differs from write");
  a_space_refused: assert property (
    !i_prog_mode |=> o_prog_rdata == 14'h0000)
    else $error("read data seen outside a programming session");
  a_cfg_held: assert property (
    !$stable(o_cfg) |-> o_core_reset || $past(o_core_reset))
    else $error("decoded options changed while running");
  a_delay_length: assert property (
    $fell(o_core_reset) && o_cfg.power_up_delay_en |-> hi_q >= POWER_UP_DELAY_TIMER_CYCLES)
    else $error("core reset released before power-up delay");
  a_read_block: assert property (
    $stable(o_cfg.code_protect_en) |->
      o_prog_mem_read_block == o_cfg.code_protect_en)
    else $error("read block disagrees with protection");
  a_osc_decode: assert property (
    o_cfg.crystal_mode == (o_cfg.osc_mode < 3'h3) &&
      o_cfg.clock_output_pin_en == (o_cfg.osc_mode[2] && o_cfg.osc_mode[0]))
    else $error("oscillator mode flags inconsistent");
  a_brownout_modes: assert property (
    o_cfg.brownout_sleep_en |-> o_cfg.brownout_run_en)
    else $error("sleep brown-out enabled without run enable");
  a_protect_range: assert property (
    o_cfg.write_protect_any |-> SELF_WRITE &&
      o_cfg.write_protect_limit inside {11'h1FF, 11'h3FF, 11'h7FF})
    else $error("bad write protect limit");
  a_pin_pullup: assert property (
    SELF_WRITE && o_cfg.ext_reset_pin_en |-> o_cfg.weak_pullup_en)
    else $error("reset pin without pull-up");
  a_osc_stop_cause: assert property (
    o_osc_stop |-> o_cfg.ext_reset_pin_en && o_cfg.osc_mode[2])
    else $error("oscillator stopped without cause");
  a_sleep_exit: assert property (
    o_sleep_exit |-> $past(i_sleeping))
    else $error("sleep exit while awake");
  a_erase_cause: assert property (
    o_prog_mem_erase |-> $past(i_prog_mode))
    else $error("erase outside a programming session");
endmodule : config_word_decode_sva
bind config_word_decode config_word_decode_sva #(
  .SELF_WRITE(SELF_WRITE), .POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) u_sva (
  .i_clock, .i_rst_n, .i_prog_mode, .i_prog_wr, .i_prog_bulk_erase,
  .i_prog_addr, .i_prog_wdata, .o_prog_rdata, .i_sleeping, .o_cfg,
  .o_core_reset, .o_sleep_exit, .o_osc_stop, .o_prog_mem_erase,
  .o_prog_mem_read_block);
`default_nettype wire

// *** dv/prog_model.sv ***
// Programmer model driving the configuration space port.
`timescale 1ns/100ps
`default_nettype none
module prog_model (
  input  wire logic        i_clock,
  input  wire logic [13:0] i_rdata,
  output logic             o_mode,
  output logic             o_wr,
  output logic             o_erase,
  output logic      [13:0] o_addr,
  output logic      [13:0] o_wdata
);
  initial
  begin
    o_mode  = 1'b0;
    o_wr    = 1'b0;
    o_erase = 1'b0;
    o_addr  = 14'h0000;
    o_wdata = 14'h0000;
  end
  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    @(posedge i_clock);
    o_mode  <= 1'b1;
    o_wr    <= 1'b1;
    o_addr  <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr    <= 1'b0;
    // Stale data is inverted so a late capture cannot look right.
    o_wdata <= ~d;
  endtask : wr
  task automatic era();
    @(posedge i_clock);
    o_mode  <= 1'b1;
    o_erase <= 1'b1;
    @(posedge i_clock);
    o_erase <= 1'b0;
  endtask : era
  task automatic rd(input logic [13:0] a, input logic m,
                    output logic [13:0] d);
    @(posedge i_clock);
    o_mode <= m;
    o_addr <= a;
    @(posedge i_clock);
    #1 d = i_rdata;
  endtask : rd
endmodule : prog_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the configuration word decoder.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int unsigned PWC = 20;
  localparam logic [13:0] CFA = config_word_pkg::CFG_WORD_ADDR;
  localparam logic [13:0] CAA = config_word_pkg::CAL_WORD_ADDR;
  logic        i_clock, i_rst_n, i_brownout_n, i_master_clear_pin;
  logic        i_osc_tick, i_sleeping, i_wdt_wake, i_irq_wake;
  logic        pm, pw, pe, core_rst, osc_stop, slp_exit, erase, rblk;
  logic [13:0] pa, pd, rdata, d, w;
  logic [1:0]  tick_q;
  int          err_count, check_count, ecnt, e, n;
  config_word_pkg::cfg_decoded_t cfg, x;
  prog_model prog (.i_clock, .i_rdata(rdata), .o_mode(pm), .o_wr(pw),
    .o_erase(pe), .o_addr(pa), .o_wdata(pd));
  config_word_decode #(.SELF_WRITE(1'b1), .POWER_UP_DELAY_TIMER_CYCLES(PWC)) uut (
    .i_clock, .i_rst_n, .i_prog_mode(pm), .i_prog_wr(pw),
    .i_prog_bulk_erase(pe), .i_prog_addr(pa), .i_prog_wdata(pd),
    .o_prog_rdata(rdata), .i_brownout_n, .i_master_clear_pin,
    .i_osc_tick, .i_sleeping, .i_wdt_wake, .i_irq_wake, .o_cfg(cfg),
    .o_core_reset(core_rst), .o_sleep_exit(slp_exit),
    .o_osc_stop(osc_stop), .o_prog_mem_erase(erase),
    .o_prog_mem_read_block(rblk));
  initial
  begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  always @(posedge i_clock)
  begin
    tick_q     <= tick_q + 2'h1;
    i_osc_tick <= tick_q[1];
    if (erase === 1'b1)
      ecnt <= ecnt + 1;
  end
  function automatic config_word_pkg::cfg_decoded_t ex(logic [13:0] v);
    ex.osc_mode = config_word_pkg::osc_mode_t'(v[2:0]);
    ex.crystal_mode = v[2:0] < 3'h3;
    ex.clock_output_pin_en = v[2] & v[0];
    ex.int_osc_8mhz = v[7];
    ex.watchdog_enable = v[3];
    ex.power_up_delay_en = ~v[4];
    ex.ext_reset_pin_en = v[5];
    ex.weak_pullup_en = v[5];
    ex.code_protect_en = ~v[6];
    ex.brownout_run_en = v[9];
    ex.brownout_sleep_en = v[9] & v[8];
    ex.write_protect_any = v[11:10] != 2'h3;
    ex.write_protect_limit = v[11] ? 11'h1FF : v[10] ? 11'h3FF : 11'h7FF;
  endfunction : ex
  task automatic cmp1(string s, logic ev, logic av);
    check_count++;
    if (av !== ev)
    begin
      err_count++;
      $display("FAIL %s exp %b got %b", s, ev, av);
    end
  endtask : cmp1
  task automatic cmp14(string s, logic [13:0] ev, logic [13:0] av);
    check_count++;
    if (av !== ev)
    begin
      err_count++;
      $display("FAIL %s exp %h got %h", s, ev, av);
    end
  endtask : cmp14
  // The limit is a don't-care while no range is protected.
  task automatic cmpc(config_word_pkg::cfg_decoded_t ev);
    x = cfg;
    if (ev.write_protect_any === 1'b0)
      x.write_protect_limit = ev.write_protect_limit;
    check_count++;
    if (x !== ev)
    begin
      err_count++;
      $display("FAIL cfg exp %h got %h", ev, cfg);
    end
  endtask : cmpc
  task automatic brown(input int gap);
    @(posedge i_clock) i_brownout_n <= 1'b0;
    repeat (6) @(posedge i_clock);
    i_brownout_n <= 1'b1;
    if (gap > 0)
    begin
      repeat (gap) @(posedge i_clock);
      i_brownout_n <= 1'b0;
      repeat (6) @(posedge i_clock);
      i_brownout_n <= 1'b1;
    end
    n = 0;
    #1;
    while (core_rst !== 1'b0 && n < 6000)
    begin
      @(posedge i_clock);
      #1 n++;
    end
    cmp1("release", 1'b1, n < 6000);
  endtask : brown
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  initial
  begin
    #(100000 * 8);
    err_count++;
    print_verdict();
  end
  initial
  begin
    {i_rst_n, i_sleeping, i_wdt_wake, i_irq_wake, tick_q} = '0;
    {i_brownout_n, i_master_clear_pin, i_osc_tick} = 3'b110;
    {err_count, check_count, ecnt} = '0;
    repeat (16) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (8) @(posedge i_clock);
    #1 cmpc(ex(14'h3FFF));
    cmp1("run", 1'b0, core_rst);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      w = {2'h3, i[1:0], 1'b1, i[0], i[1] ^ i[0], i[1], i[2], i[1], i[0],
           i[2:0]};
      prog.wr(CFA, w);
      prog.rd(CFA, 1'b1, d);
      cmp14("cfg_read", w | 14'h3000, d);
      brown(0);
      cmpc(ex(w));
      cmp1("read_block", ~w[6], rblk);
      if (w[2:0] < 3'h3)
        cmp1("xtal_hold", 1'b1, n > 4000);
      else
        cmp1("delay_hold", ~w[4], n >= PWC);
    end
    $display("test decode done");
    prog.wr(CFA, 14'h3FEB);
    brown(0);
    brown(10);
    cmp1("restart", 1'b1, n >= PWC);
    prog.wr(CFA, 14'h3FFF);
    repeat (4) @(posedge i_clock);
    #1 cmpc(ex(14'h3FEB));
    e = ecnt;
    prog.wr(CFA, 14'h3FBF);
    prog.wr(CFA, 14'h3FFF);
    repeat (3) @(posedge i_clock);
    #1 cmp1("erase_once", 1'b1, ecnt == e + 1);
    prog.wr(CAA, 14'h15A5);
    prog.era();
    prog.rd(CAA, 1'b1, d);
    cmp14("cal_kept", 14'h15A5, d);
    prog.rd(CFA, 1'b1, d);
    cmp14("erased", 14'h3FFF, d);
    prog.rd(CFA, 1'b0, d);
    cmp14("no_session", 14'h0000, d);
    prog.rd(14'h1FFF, 1'b1, d);
    cmp14("user_space", 14'h0000, d);
    $display("test programmer done");
    prog.wr(CFA, 14'h3FFC);
    brown(0);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge i_clock);
      i_sleeping <= 1'b1;
      i_irq_wake <= (k == 0);
      i_wdt_wake <= (k == 1);
      i_master_clear_pin <= (k != 2);
      repeat (6) @(posedge i_clock);
      #1 cmp1("wake", k < 3, slp_exit);
      if (k == 2)
        cmp1("osc_stop", 1'b1, osc_stop);
      if (k == 2)
        cmp1("pin_reset", 1'b1, core_rst);
    end
    @(posedge i_clock) i_sleeping <= 1'b0;
    repeat (8) @(posedge i_clock);
    #1 cmp1("pin_free", 1'b0, core_rst);
    prog.wr(CFA, 14'h3FDC);
    brown(0);
    @(posedge i_clock) i_master_clear_pin <= 1'b0;
    repeat (6) @(posedge i_clock);
    #1 cmp1("pin_io", 1'b0, core_rst);
    cmp1("osc_run", 1'b0, osc_stop);
    $display("test pin and sleep done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
